// >>> nvsc_pkg.sv
package nvsc_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 16;
   localparam logic [15:0] SEQ_ADDR [0:4] = '{16'h4E38, 16'hB1C7, 16'h83E0,
      16'h7C1F, 16'h703F};
   localparam logic [15:0] TRIG_SAVE = 16'h8FC0;
   localparam logic [15:0] TRIG_RESTORE = 16'h4C63;
   localparam logic [15:0] TRIG_AUTO_OFF = 16'h8B45;
   localparam logic [15:0] TRIG_AUTO_ON = 16'h4B46;
   localparam int CLK_MHZ = 40;
   // Bus phase lengths in cycles, some set in ns and rounded up
   localparam int SETUP_CYC = 1;
   localparam int ACCESS_NS = 100;
   localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int STORE_DELAY_NS = 1000;
   localparam int STORE_DELAY_CYC = (STORE_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int SEQ_LEN = 6;
   // Pin synchroniser latency, waited out after a sequence
   localparam int SETTLE_CYC = 4;
   typedef enum logic [2:0] {
      NVSC_CMD_READ = 3'h0,
      NVSC_CMD_WRITE = 3'h1,
      NVSC_CMD_SAVE = 3'h2,
      NVSC_CMD_RESTORE = 3'h3,
      NVSC_CMD_AUTO_OFF = 3'h4,
      NVSC_CMD_AUTO_ON = 3'h5,
      NVSC_CMD_PIN_SAVE = 3'h6
   } nvsc_cmd_t;
endpackage

// >>> nvsc_cyc_if.sv
`timescale 1ns/1ps
interface nvsc_cyc_if;
   import nvsc_pkg::*;
   logic start;
   logic write;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [1:0] lanes;
   logic done;
   logic [DATA_W-1:0] rdata;
   modport ctrl (output start, write, addr, wdata, lanes,
      input done, rdata);
   modport cyc (input start, write, addr, wdata, lanes,
      output done, rdata);
endinterface

// >>> nvsc_cycle.sv
`timescale 1ns/1ps
module nvsc_cycle
   import nvsc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Sequencer side
   nvsc_cyc_if.cyc c,
   // Memory pins
   output logic [ADDR_W-1:0] mem_addr,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_n,
   output logic upper_byte_lane_n,
   output logic lower_byte_lane_n,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_n
);
   typedef enum logic [1:0] {
      NVSC_CY_IDLE = 2'b00,
      NVSC_CY_SETUP = 2'b01,
      NVSC_CY_ACT = 2'b10,
      NVSC_CY_HOLD = 2'b11
   } nvsc_cy_t;
   nvsc_cy_t state_reg;
   logic [7:0] cnt_reg;
   logic wr_reg;
   logic [DATA_W-1:0] rdata_reg;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= NVSC_CY_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
      end else begin
         case (state_reg)
            NVSC_CY_IDLE: begin
               if (c.start) begin
                  wr_reg <= c.write;
                  cnt_reg <= 8'(SETUP_CYC);
                  state_reg <= NVSC_CY_SETUP;
               end
            end
            NVSC_CY_SETUP: begin
               if (cnt_reg <= 8'h01) begin
                  cnt_reg <= 8'(ACCESS_CYC);
                  state_reg <= NVSC_CY_ACT;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            NVSC_CY_ACT: begin
               if (cnt_reg <= 8'h01) begin
                  state_reg <= NVSC_CY_HOLD;
               end else begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            NVSC_CY_HOLD: state_reg <= NVSC_CY_IDLE;
            default: state_reg <= NVSC_CY_IDLE;
         endcase
      end
   end

   // Address, lanes and data held from setup until strobes rise
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mem_addr <= '0;
         dq_out <= '0;
         upper_byte_lane_n <= 1'b1;
         lower_byte_lane_n <= 1'b1;
      end else if (state_reg == NVSC_CY_IDLE && c.start) begin
         mem_addr <= c.addr;
         dq_out <= c.wdata;
         upper_byte_lane_n <= ~c.lanes[1];
         lower_byte_lane_n <= ~c.lanes[0];
      end
   end

   // Strobes go active only after address is stable
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chip_sel_n <= 1'b1;
         out_en_n <= 1'b1;
         write_n <= 1'b1;
         dq_oe_n <= 1'b1;
      end else begin
         chip_sel_n <= !(state_reg == NVSC_CY_SETUP && cnt_reg <= 8'h01
            || state_reg == NVSC_CY_ACT && cnt_reg > 8'h01);
         out_en_n <= !(!wr_reg && (state_reg == NVSC_CY_SETUP
            && cnt_reg <= 8'h01 || state_reg == NVSC_CY_ACT
            && cnt_reg > 8'h01));
         write_n <= !(wr_reg && (state_reg == NVSC_CY_SETUP
            && cnt_reg <= 8'h01 || state_reg == NVSC_CY_ACT
            && cnt_reg > 8'h01));
         dq_oe_n <= !(wr_reg && state_reg != NVSC_CY_IDLE
            && !(state_reg == NVSC_CY_HOLD));
      end
   end

   // Sample at end of access, before select rises
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (state_reg == NVSC_CY_ACT && cnt_reg <= 8'h01
         && !wr_reg) begin
         rdata_reg <= dq_in;
      end
   end

   assign c.rdata = rdata_reg;
   assign c.done = (state_reg == NVSC_CY_HOLD);
endmodule

// >>> nvsc_ctrl.sv
`timescale 1ns/1ps
module nvsc_ctrl
   import nvsc_pkg::*;
#(
   parameter int STORE_DELAY = STORE_DELAY_CYC
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // User command port
   input wire logic cmd_valid,
   input wire nvsc_cmd_t cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_wdata,
   input wire logic [1:0] cmd_lanes,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic nv_busy,
   // Memory pins
   output logic [ADDR_W-1:0] mem_addr,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic write_n,
   output logic upper_byte_lane_n,
   output logic lower_byte_lane_n,
   input wire logic [DATA_W-1:0] dq_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   // Open-drain store busy pin
   input wire logic store_busy_n_in,
   output logic store_busy_n_out,
   output logic store_busy_n_oe_n
);
   typedef enum logic [2:0] {
      NVSC_IDLE = 3'b000,
      NVSC_RUN = 3'b001,
      NVSC_WAIT = 3'b010,
      NVSC_PIN = 3'b011,
      NVSC_PINREL = 3'b100,
      NVSC_SETTLE = 3'b101
   } nvsc_st_t;

   nvsc_cyc_if cy ();
   nvsc_st_t state_reg;
   nvsc_cmd_t op_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [1:0] lanes_reg;
   logic [2:0] step_reg;
   logic [15:0] dly_reg;
   logic [2:0] hsb_sync_reg;
   logic hsb_reg;
   logic launch;
   // Command accepted this cycle
   logic take;
   logic plain_op;
   logic cyc_last;

   // Three-stage pin synchroniser, change accepted when the last two stages agree
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hsb_sync_reg <= 3'b111;
         hsb_reg <= 1'b1;
      end else begin
         hsb_sync_reg <= {hsb_sync_reg[1:0], store_busy_n_in};
         if (hsb_sync_reg[2] == hsb_sync_reg[1]) begin
            hsb_reg <= hsb_sync_reg[1];
         end
      end
   end

   // Low busy pin means save, restore or brownout in progress
   assign cmd_ready = state_reg == NVSC_IDLE && hsb_reg;
   assign nv_busy = !hsb_reg;
   assign store_busy_n_out = 1'b0;
   assign store_busy_n_oe_n = !(state_reg == NVSC_PIN);
   assign take = cmd_valid && cmd_ready;
   // Plain accesses end after one bus cycle, sequences after six
   assign plain_op = op_reg == NVSC_CMD_READ || op_reg == NVSC_CMD_WRITE;
   assign cyc_last = state_reg == NVSC_WAIT && cy.done
      && (plain_op || step_reg == 3'(SEQ_LEN - 1));

   // Which address the current step issues
   always_comb begin
      launch = 1'b0;
      cy.write = 1'b0;
      cy.addr = addr_reg;
      if (state_reg == NVSC_RUN) begin
         launch = 1'b1;
         cy.write = (op_reg == NVSC_CMD_WRITE);
         if (op_reg != NVSC_CMD_READ && op_reg != NVSC_CMD_WRITE) begin
            // Sequences sit in bits 15:0, bits 1:0 and 15 unused
            if (step_reg < 3'(SEQ_LEN - 1)) begin
               cy.addr = ADDR_W'(SEQ_ADDR[step_reg]);
            end else begin
               case (op_reg)
                  NVSC_CMD_SAVE: cy.addr = ADDR_W'(TRIG_SAVE);
                  NVSC_CMD_RESTORE: cy.addr = ADDR_W'(TRIG_RESTORE);
                  NVSC_CMD_AUTO_OFF: cy.addr = ADDR_W'(TRIG_AUTO_OFF);
                  NVSC_CMD_AUTO_ON: cy.addr = ADDR_W'(TRIG_AUTO_ON);
                  default: cy.addr = addr_reg;
               endcase
            end
         end
      end
   end
   assign cy.start = launch;
   assign cy.wdata = wdata_reg;
   assign cy.lanes = (op_reg == NVSC_CMD_READ || op_reg == NVSC_CMD_WRITE)
      ? lanes_reg : 2'b11;

   // Operands captured once per accepted command
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         op_reg <= NVSC_CMD_READ;
         addr_reg <= '0;
         wdata_reg <= '0;
         lanes_reg <= 2'b00;
      end else if (take) begin
         op_reg <= cmd_op;
         addr_reg <= cmd_addr;
         wdata_reg <= cmd_wdata;
         lanes_reg <= cmd_lanes;
      end
   end

   // Sequence step, restarted by every command
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         step_reg <= 3'h0;
      end else if (take) begin
         step_reg <= 3'h0;
      end else if (state_reg == NVSC_WAIT && cy.done && !cyc_last) begin
         step_reg <= step_reg + 3'h1;
      end
   end

   // One down-counter times both the pin hold and the settle wait
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dly_reg <= 16'h0000;
      end else if (take) begin
         dly_reg <= 16'(STORE_DELAY);
      end else if (cyc_last) begin
         dly_reg <= 16'(SETTLE_CYC);
      end else if (dly_reg > 16'h0001) begin
         dly_reg <= dly_reg - 16'h0001;
      end
   end

   // Main command sequencer
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_reg <= NVSC_IDLE;
      end else begin
         case (state_reg)
            NVSC_IDLE: begin
               if (take) begin
                  state_reg <= (cmd_op == NVSC_CMD_PIN_SAVE)
                     ? NVSC_PIN : NVSC_RUN;
               end
            end
            NVSC_RUN: state_reg <= NVSC_WAIT;
            NVSC_WAIT: begin
               if (cyc_last && plain_op) begin
                  state_reg <= NVSC_IDLE;
               end else if (cyc_last) begin
                  // Busy pin shows only after the synchroniser delay
                  state_reg <= NVSC_SETTLE;
               end else if (cy.done) begin
                  // Six back-to-back reads, nothing interleaved
                  state_reg <= NVSC_RUN;
               end
            end
            // Hold pin low past the request delay, then release
            NVSC_PIN: begin
               if (dly_reg <= 16'h0001) begin
                  state_reg <= NVSC_PINREL;
               end
            end
            NVSC_PINREL: state_reg <= NVSC_IDLE;
            // Refuse commands until a started save shows on the pin
            NVSC_SETTLE: begin
               if (dly_reg <= 16'h0001) begin
                  state_reg <= NVSC_IDLE;
               end
            end
            default: state_reg <= NVSC_IDLE;
         endcase
      end
   end

   // Read data kept until the next bus cycle ends
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= cyc_last || state_reg == NVSC_PINREL;
         if (state_reg == NVSC_WAIT && cy.done) begin
            rsp_rdata <= cy.rdata;
         end
      end
   end

   nvsc_cycle u_cycle (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .c(cy.cyc),
      .mem_addr(mem_addr),
      .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n),
      .write_n(write_n),
      .upper_byte_lane_n(upper_byte_lane_n),
      .lower_byte_lane_n(lower_byte_lane_n),
      .dq_in(dq_in),
      .dq_out(dq_out),
      .dq_oe_n(dq_oe_n)
   );
endmodule

// >>> nvsc_ctrl_asserts.sv
`timescale 1ns/1ps
module nvsc_ctrl_asserts
   import nvsc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // User side
   input wire logic cmd_valid,
   input wire nvsc_cmd_t cmd_op,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic nv_busy,
   // Memory pins
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_n,
   input wire logic upper_byte_lane_n,
   input wire logic lower_byte_lane_n,
   input wire logic dq_oe_n,
   input wire logic store_busy_n_in,
   input wire logic store_busy_n_oe_n
);
   logic take;
   logic seq_act;
   assign take = cmd_valid && cmd_ready;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Software sequence in flight
   always_ff @(posedge core_clk) begin
      if (!rst_n || rsp_valid) begin
         seq_act <= 1'b0;
      end else if (take) begin
         seq_act <= cmd_op inside {NVSC_CMD_SAVE, NVSC_CMD_RESTORE,
            NVSC_CMD_AUTO_OFF, NVSC_CMD_AUTO_ON};
      end
   end
   a_oe_in_write: assert property (!write_n |-> out_en_n)
      else $error("oe low in write");
   a_read_bus: assert property (!out_en_n |-> dq_oe_n && !chip_sel_n)
      else $error("bad read strobes");
   a_write_bus: assert property (!write_n |-> !dq_oe_n && !chip_sel_n)
      else $error("bad write strobes");
   a_addr_hold: assert property (!write_n && !$past(write_n) |->
      $stable(mem_addr)) else $error("address moved in write");
   a_busy_refuse: assert property (nv_busy |-> !cmd_ready)
      else $error("ready while busy");
   a_pin_sync: assert property (!store_busy_n_in [*3] |-> ##2 nv_busy)
      else $error("busy pin not seen");
   a_seq_settle: assert property (rsp_valid && seq_act |-> !cmd_ready)
      else $error("ready right after sequence");
   a_read_answer: assert property (take && cmd_op == NVSC_CMD_READ
      |-> ##[2:12] rsp_valid) else $error("read unanswered");
   a_pin_request: assert property (take && cmd_op == NVSC_CMD_PIN_SAVE
      |-> ##[1:2] !store_busy_n_oe_n) else $error("pin not pulled");
   a_seq_strobe: assert property (seq_act |-> write_n)
      else $error("write in sequence");
   a_seq_lanes: assert property (seq_act && !chip_sel_n |->
      !upper_byte_lane_n && !lower_byte_lane_n) else $error("lanes off");
endmodule
bind nvsc_ctrl nvsc_ctrl_asserts i_nvsc_ctrl_asserts (.core_clk, .rst_n,
   .cmd_valid, .cmd_op, .cmd_ready, .rsp_valid, .nv_busy, .mem_addr,
   .chip_sel_n, .out_en_n, .write_n, .upper_byte_lane_n,
   .lower_byte_lane_n, .dq_oe_n, .store_busy_n_in, .store_busy_n_oe_n);

// >>> nvsc_mem_model.sv
`timescale 1ns/1ps
module nvsc_mem_model
   import nvsc_pkg::*;
#(
   parameter int T = 20
)
(
   // Clock and supply
   input wire logic core_clk,
   input wire logic pwr_ok,
   // Memory pins
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic write_n,
   input wire logic upper_byte_lane_n,
   input wire logic lower_byte_lane_n,
   input wire logic [DATA_W-1:0] dq_out,
   output logic [DATA_W-1:0] dq_in,
   // Busy pin
   input wire logic sb_pin,
   output logic pull
);
   logic [15:0] mem [256];
   logic [15:0] nv [256];
   logic [15:0] v, m;
   logic [12:0] a_q;
   logic drv, rd_q = 0, pwr_q = 0, wl = 0, auto_en = 1;
   int cnt = 0, dly = 0, step = 0;
   assign drv = !chip_sel_n && !out_en_n && write_n && sb_pin && cnt == 0;
   assign v = mem[mem_addr[7:0]];
   // Released lanes show the inverse, never a stale byte
   assign m = {{8{!upper_byte_lane_n}}, {8{!lower_byte_lane_n}}}
      & {16{drv}};
   assign dq_in = (v & m) | (~v & ~m);
   assign pull = cnt != 0;
   function automatic logic [12:0] k(logic [15:0] a);
      return a[14:2];
   endfunction
   initial begin
      foreach (nv[i]) begin
         mem[i] = 0;
         nv[i] = 0;
      end
   end
   always @(posedge core_clk) begin
      pwr_q <= pwr_ok;
      rd_q <= drv;
      a_q <= k(mem_addr[15:0]);
      if (cnt != 0) begin
         cnt <= cnt - 1;
      end else if (pwr_ok && !pwr_q) begin
         foreach (mem[i]) mem[i] = nv[i];
         cnt <= T;
         wl <= 0;
      end else if (!pwr_ok) begin
         if (pwr_q && auto_en && wl) begin
            foreach (nv[i]) nv[i] = mem[i];
            wl <= 0;
         end
      end else if (!sb_pin) begin
         dly <= dly + 1;
         if (dly == 1 && wl) begin
            foreach (nv[i]) nv[i] = mem[i];
            wl <= 0;
            cnt <= T;
         end
      end else if (!chip_sel_n && !write_n) begin
         if (!upper_byte_lane_n) mem[mem_addr[7:0]][15:8] = dq_out[15:8];
         if (!lower_byte_lane_n) mem[mem_addr[7:0]][7:0] = dq_out[7:0];
         wl <= 1;
         step <= 0;
      end else if (rd_q && !drv && step < 5) begin
         step <= a_q == k(SEQ_ADDR[step]) ? step + 1
            : int'(a_q == k(SEQ_ADDR[0]));
      end else if (rd_q && !drv) begin
         step <= 0;
         if (a_q == k(TRIG_SAVE)) begin
            foreach (nv[i]) nv[i] = mem[i];
            cnt <= T;
            wl <= 0;
         end
         if (a_q == k(TRIG_RESTORE)) begin
            foreach (mem[i]) mem[i] = 0;
            foreach (mem[i]) mem[i] = nv[i];
            cnt <= T;
            wl <= 0;
         end
         if (a_q == k(TRIG_AUTO_OFF)) auto_en <= 0;
         if (a_q == k(TRIG_AUTO_ON)) auto_en <= 1;
      end
      if (sb_pin) dly <= 0;
   end
endmodule

// >>> test_nvsc_ctrl.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
   $display("wrong value at %0t: %h not %h", $time, a, b); end end
module test_nvsc_ctrl
   import nvsc_pkg::*;
;
   logic core_clk = 0, rst_n = 0, cmd_valid = 0, pwr_ok = 0;
   nvsc_cmd_t cmd_op = NVSC_CMD_READ;
   logic [ADDR_W-1:0] cmd_addr = '0, mem_addr;
   logic [DATA_W-1:0] cmd_wdata = '0, rsp_rdata, dq_in, dq_out;
   logic [1:0] cmd_lanes = 2'h3;
   logic cmd_ready, rsp_valid, nv_busy, chip_sel_n, out_en_n, write_n;
   logic upper_byte_lane_n, lower_byte_lane_n, dq_oe_n, pull, sb_pin;
   logic store_busy_n_out, store_busy_n_oe_n;
   int failures = 0, tests_run = 0, n;
   always #12.5 core_clk = ~core_clk;
   // Open-drain busy wire with pull-up
   assign sb_pin = ~((~store_busy_n_oe_n & ~store_busy_n_out) | pull);
   nvsc_ctrl #(.STORE_DELAY(4)) i_nvsc_ctrl (.core_clk, .rst_n, .cmd_valid,
      .cmd_op, .cmd_addr, .cmd_wdata, .cmd_lanes, .cmd_ready, .rsp_valid,
      .rsp_rdata, .nv_busy, .mem_addr, .chip_sel_n, .out_en_n, .write_n,
      .upper_byte_lane_n, .lower_byte_lane_n, .dq_in, .dq_out, .dq_oe_n,
      .store_busy_n_in(sb_pin), .store_busy_n_out, .store_busy_n_oe_n);
   nvsc_mem_model i_nvsc_mem_model (.core_clk, .pwr_ok, .mem_addr,
      .chip_sel_n, .out_en_n, .write_n, .upper_byte_lane_n,
      .lower_byte_lane_n, .dq_out, .dq_in, .sb_pin, .pull);
   task automatic results;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge core_clk);
      #2;
   endtask
   // Waits out busy phases too, so the bound covers a full save
   task automatic cmd(nvsc_cmd_t op, logic [ADDR_W-1:0] a,
      logic [15:0] d, logic [1:0] l);
      cmd_op = op;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_lanes = l;
      cmd_valid = 1;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      tick(1);
      cmd_valid = 0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      if (n >= 400) begin
         failures++;
         results;
      end
   endtask
   task automatic power_cycle;
      pwr_ok = 0;
      tick(3);
      pwr_ok = 1;
      tick(5);
      `CHK(nv_busy, 1'b1)
   endtask
   task automatic t_rw;
      cmd(NVSC_CMD_WRITE, 5, 16'h1234, 2'h3);
      cmd(NVSC_CMD_WRITE, 5, 16'hFFAB, 2'h1);
      cmd(NVSC_CMD_WRITE, 6, 16'hBEEF, 2'h3);
      cmd(NVSC_CMD_READ, 5, 16'h0, 2'h3);
      `CHK(rsp_rdata, 16'h12AB)
      cmd(NVSC_CMD_READ, 6, 16'h0, 2'h3);
      `CHK(rsp_rdata, 16'hBEEF)
      $display("rw done");
   endtask
   task automatic t_nv;
      cmd(NVSC_CMD_SAVE, 0, 16'h0, 2'h3);
      tick(5);
      `CHK(nv_busy, 1'b1)
      cmd(NVSC_CMD_WRITE, 5, 16'h0, 2'h3);
      cmd(NVSC_CMD_RESTORE, 0, 16'h0, 2'h3);
      cmd(NVSC_CMD_READ, 5, 16'h0, 2'h3);
      `CHK(rsp_rdata, 16'h12AB)
      cmd(NVSC_CMD_SAVE, 0, 16'h0, 2'h3);
      tick(5);
      `CHK(nv_busy, 1'b1)
      $display("nv done");
   endtask
   task automatic t_pin;
      cmd(NVSC_CMD_PIN_SAVE, 0, 16'h0, 2'h3);
      tick(5);
      `CHK(nv_busy, 1'b0)
      cmd(NVSC_CMD_WRITE, 7, 16'h0F0F, 2'h3);
      cmd(NVSC_CMD_PIN_SAVE, 0, 16'h0, 2'h3);
      tick(3);
      `CHK(nv_busy, 1'b1)
      $display("pin done");
   endtask
   task automatic t_auto;
      cmd(NVSC_CMD_AUTO_OFF, 0, 16'h0, 2'h3);
      cmd(NVSC_CMD_WRITE, 9, 16'h5A5A, 2'h3);
      power_cycle;
      cmd(NVSC_CMD_READ, 9, 16'h0, 2'h3);
      `CHK(rsp_rdata, 16'h0000)
      cmd(NVSC_CMD_AUTO_ON, 0, 16'h0, 2'h3);
      cmd(NVSC_CMD_WRITE, 9, 16'h5A5A, 2'h3);
      power_cycle;
      cmd(NVSC_CMD_READ, 9, 16'h0, 2'h3);
      `CHK(rsp_rdata, 16'h5A5A)
      $display("auto done");
   endtask
   initial begin
      tick(5);
      rst_n = 1;
      pwr_ok = 1;
      tick(5);
      `CHK(nv_busy, 1'b1)
      t_rw;
      t_nv;
      t_pin;
      t_auto;
      results;
   end
endmodule
